/* bscp_defs.vh */
// constants for the boot source and code protection block
`ifndef BSCP_DEFS_VH
`define BSCP_DEFS_VH
// **********************************
// special setting register indexes
// **********************************
`define BSCP_IDX_SEC     2'h0
`define BSCP_IDX_MAKER   2'h1
`define BSCP_IDX_DEVICE  2'h2
// **********************************
// security byte field positions
// **********************************
`define BSCP_SB_LOCK     0
`define BSCP_SB_CTR      1
`define BSCP_SB_P2BOOT   4
`define BSCP_SB_P4BOOT   5
`define BSCP_SB_XTAL     7
`define BSCP_SEC_ERASED  8'hff
// **********************************
// boot control codes
// **********************************
`define BSCP_BC_RESET    8'h00
`define BSCP_BC_UPDATE   8'h01
`define BSCP_BC_LOADER   8'h03
`define BSCP_BC_SWREBOOT 8'h83
// **********************************
// flash target select codes
// **********************************
`define BSCP_TS_BANK0    2'h0
`define BSCP_TS_BANK1    2'h1
`define BSCP_TS_LOADER   2'h2
`define BSCP_TS_RESET    2'h0
// **********************************
// timing counts
// **********************************
`define BSCP_RST_PULSE   4'h8
`endif

/* bscp_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module bscp_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout_q
);
  reg [W-1:0] meta_q;
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      dout_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end
endmodule // bscp_sync

/* bscp_secmem.v */
// special setting registers: security byte and identification codes
`timescale 1ns/10ps
`include "bscp_defs.vh"
module bscp_secmem #(
  parameter [7:0] MAKER_ID  = 8'h5a,
  parameter [7:0] DEVICE_ID = 8'h3c
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       wr,
  input  wire       erase_all,
  input  wire [7:0] wdata,
  input  wire       rd,
  input  wire [1:0] addr,
  output reg  [7:0] rdata_q,
  output reg  [7:0] sec_q
);
  // **********************************
  // security byte storage
  // **********************************
  always @(posedge clk) begin
    if (rst) begin
      sec_q <= `BSCP_SEC_ERASED;
    end else if (erase_all) begin
      sec_q <= `BSCP_SEC_ERASED; // R8
    end else if (wr) begin
      sec_q <= sec_q & wdata; // R8
    end
  end
  // **********************************
  // registered read port
  // **********************************
  always @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        `BSCP_IDX_SEC:    rdata_q <= sec_q;
        `BSCP_IDX_MAKER:  rdata_q <= MAKER_ID; // R14
        `BSCP_IDX_DEVICE: rdata_q <= DEVICE_ID; // R14
        default:          rdata_q <= 8'h00;
      endcase
    end
  end
endmodule // bscp_secmem

/* bscp_top.v */
// boot source selection and code protection
// Function
// (R1) after external reset boot from application flash unless an enabled strap asks
// (R2) security bit 4 low and port2 bits 6,7 low at reset: boot loader
// (R3) security bit 5 low and port4 bit 3 low at reset: boot loader
// (R4) boot control 03h at idle entry: switch to loader and reset
// (R5) writing 83h to boot control: back to application flash and reset
// (R6) boot control 01h at idle entry: update flash, continue without reset
// (R7) target select picks application bank 0, bank 1 or loader flash
// (R8) security bits only go 1 to 0; erase-all restores ffh
// (R9) security and id registers inaccessible in flash programming mode
// (R10) security bit 0 low blocks flash and special register reads
// (R11) security bit 1 low: external code-table reads reach only external memory
// (R12) internal code-table reads always reach internal and external memory
// (R13) programmer sets bit 7 high above 24 mhz crystal, low below
// (R14) maker and device ids fixed, not writable
// (R15) straps and security byte sampled at external reset release
`timescale 1ns/10ps
`include "bscp_defs.vh"
module bscp_top #(
  parameter [7:0] MAKER_ID  = 8'h5a,
  parameter [7:0] DEVICE_ID = 8'h3c
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       ext_reset_pin,
  input  wire       port2_bit6_strap,
  input  wire       port2_bit7_strap,
  input  wire       port4_bit3_strap,
  input  wire       core_idle_enter,
  input  wire       boot_ctrl_wr,
  input  wire [7:0] boot_ctrl_wdata,
  input  wire       target_sel_wr,
  input  wire [1:0] target_sel_wdata,
  input  wire       update_done,
  input  wire       code_table_read,
  input  wire       ctr_from_external,
  input  wire       ctr_addr_internal,
  input  wire       flash_rd_req,
  input  wire       spec_wr,
  input  wire       spec_erase_all,
  input  wire [7:0] spec_wdata,
  input  wire       spec_rd,
  input  wire [1:0] spec_addr,
  output reg        core_reset_q,
  output reg        boot_from_loader_q,
  output reg        update_busy_q,
  output reg  [1:0] flash_target_q,
  output reg  [7:0] flash_boot_control_q,
  output reg        ctr_to_internal_q,
  output reg        ctr_to_external_q,
  output reg        flash_rd_grant_q,
  output reg        spec_refused_q,
  output reg  [7:0] spec_rdata_q,
  output reg        spec_rvalid_q,
  output reg        crystal_fast_q,
  output reg  [7:0] sec_latched_q
);
  // **********************************
  // pin synchronisers
  // **********************************
  wire ext_rst_s;
  wire p26_s;
  wire p27_s;
  wire p43_s;
  bscp_sync #(
    .W (1)
  ) u_sync_rst (
    .clk    (clk),
    .rst    (rst),
    .din    (ext_reset_pin),
    .dout_q (ext_rst_s)
  );
  bscp_sync #(
    .W (1)
  ) u_sync_p26 (
    .clk    (clk),
    .rst    (rst),
    .din    (port2_bit6_strap),
    .dout_q (p26_s)
  );
  bscp_sync #(
    .W (1)
  ) u_sync_p27 (
    .clk    (clk),
    .rst    (rst),
    .din    (port2_bit7_strap),
    .dout_q (p27_s)
  );
  bscp_sync #(
    .W (1)
  ) u_sync_p43 (
    .clk    (clk),
    .rst    (rst),
    .din    (port4_bit3_strap),
    .dout_q (p43_s)
  );

  // **********************************
  // special setting registers
  // **********************************
  wire [7:0] sec_byte;
  wire [7:0] mem_rdata;
  wire       prog_mode    = update_busy_q | boot_from_loader_q;
  wire       spec_ok      = ~prog_mode; // R9
  wire       lock_n       = sec_latched_q[`BSCP_SB_LOCK];
  wire       sec_wr_en    = spec_wr & spec_ok & (spec_addr == `BSCP_IDX_SEC); // R9 R14
  wire       sec_erase_en = spec_erase_all & spec_ok; // R8 R9
  wire       spec_rd_ok   = spec_rd & spec_ok & lock_n; // R9 R10
  wire       spec_refuse  = (spec_rd & ~spec_rd_ok) | ((spec_wr | spec_erase_all) & ~spec_ok);

  // **********************************
  // special setting register storage
  // **********************************
  bscp_secmem #(
    .MAKER_ID  (MAKER_ID),
    .DEVICE_ID (DEVICE_ID)
  ) u_secmem (
    .clk       (clk),
    .rst       (rst),
    .wr        (sec_wr_en), // R9 R14
    .erase_all (sec_erase_en), // R8 R9
    .wdata     (spec_wdata),
    .rd        (spec_rd_ok), // R9 R10
    .addr      (spec_addr),
    .rdata_q   (mem_rdata),
    .sec_q     (sec_byte)
  );

  // **********************************
  // special register read answer
  // **********************************
  reg spec_rd_ok_q;
  always @(posedge clk) begin
    if (rst) begin
      spec_rd_ok_q   <= 1'b0;
      spec_refused_q <= 1'b0;
    end else begin
      spec_rd_ok_q   <= spec_rd_ok; // R10
      spec_refused_q <= spec_refuse; // R9 R10
    end
  end

  // **********************************
  // special register read data
  // **********************************
  always @(posedge clk) begin
    if (rst) begin
      spec_rdata_q  <= 8'h00;
      spec_rvalid_q <= 1'b0;
    end else begin
      spec_rvalid_q <= spec_rd_ok_q;
      spec_rdata_q  <= spec_rd_ok_q ? mem_rdata : 8'h00;
    end
  end

  // **********************************
  // reset release detection and boot choice
  // **********************************
  reg  ext_rst_prev_q;
  wire ext_release = ext_rst_prev_q & ~ext_rst_s;
  wire p2_reboot = ~sec_byte[`BSCP_SB_P2BOOT] & ~p26_s & ~p27_s; // R2
  wire p4_reboot = ~sec_byte[`BSCP_SB_P4BOOT] & ~p43_s; // R3
  always @(posedge clk) begin
    if (rst) begin
      ext_rst_prev_q <= 1'b0;
    end else begin
      ext_rst_prev_q <= ext_rst_s;
    end
  end

  // **********************************
  // security byte latch at reset release
  // **********************************
  always @(posedge clk) begin
    if (rst) begin
      sec_latched_q  <= `BSCP_SEC_ERASED;
      crystal_fast_q <= 1'b1;
    end else if (ext_release) begin
      sec_latched_q  <= sec_byte; // R15
      crystal_fast_q <= sec_byte[`BSCP_SB_XTAL]; // R13
    end
  end

  // **********************************
  // boot control and update sequencing
  // **********************************
  localparam ST_RUN    = 2'h0;
  localparam ST_UPDATE = 2'h1;
  localparam ST_RESET  = 2'h2;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] pulse_q;
  reg [3:0] pulse_d;
  reg       loader_d;
  reg [7:0] bctl_d;
  wire      sw_reboot_req = boot_ctrl_wr & (boot_ctrl_wdata == `BSCP_BC_SWREBOOT); // R5
  wire      idle_loader   = core_idle_enter & (flash_boot_control_q == `BSCP_BC_LOADER); // R4
  wire      idle_update   = core_idle_enter & (flash_boot_control_q == `BSCP_BC_UPDATE); // R6
  always @* begin
    state_d  = state_q;
    pulse_d  = pulse_q;
    loader_d = boot_from_loader_q;
    bctl_d   = flash_boot_control_q;
    if (ext_rst_s) begin
      state_d = ST_RESET;
      pulse_d = 4'h0;
      bctl_d  = `BSCP_BC_RESET;
    end else if (ext_release) begin
      state_d  = ST_RUN;
      loader_d = p2_reboot | p4_reboot; // R1 R15
    end else begin
      case (state_q)
        ST_RUN: begin
          if (sw_reboot_req) begin
            loader_d = 1'b0; // R5
            bctl_d   = `BSCP_BC_RESET;
            pulse_d  = `BSCP_RST_PULSE;
            state_d  = ST_RESET;
          end else if (boot_ctrl_wr) begin
            bctl_d = boot_ctrl_wdata;
          end else if (idle_loader) begin
            loader_d = 1'b1; // R4
            bctl_d   = `BSCP_BC_RESET;
            pulse_d  = `BSCP_RST_PULSE;
            state_d  = ST_RESET;
          end else if (idle_update) begin
            state_d = ST_UPDATE; // R6
          end
        end
        ST_UPDATE: begin
          if (update_done) begin
            state_d = ST_RUN; // R6
          end
        end
        ST_RESET: begin
          if (pulse_q != 4'h0) begin
            pulse_d = pulse_q - 4'h1;
          end else begin
            state_d = ST_RUN;
          end
        end
        default: begin
          state_d = ST_RUN;
        end
      endcase
    end
  end

  // **********************************
  // boot control registers
  // **********************************
  always @(posedge clk) begin
    if (rst) begin
      state_q              <= ST_RESET;
      pulse_q              <= 4'h0;
      boot_from_loader_q   <= 1'b0;
      flash_boot_control_q <= `BSCP_BC_RESET;
      core_reset_q         <= 1'b1;
      update_busy_q        <= 1'b0;
    end else begin
      state_q              <= state_d;
      pulse_q              <= pulse_d;
      boot_from_loader_q   <= loader_d;
      flash_boot_control_q <= bctl_d;
      core_reset_q         <= (state_d == ST_RESET);
      update_busy_q        <= (state_d == ST_UPDATE);
    end
  end

  // **********************************
  // flash target select
  // **********************************
  always @(posedge clk) begin
    if (rst || ext_rst_s) begin
      flash_target_q <= `BSCP_TS_RESET;
    end else if (target_sel_wr && target_sel_wdata <= `BSCP_TS_LOADER) begin
      flash_target_q <= target_sel_wdata; // R7
    end
  end

  // **********************************
  // code-table read routing
  // **********************************
  wire ctr_int_ok = ~ctr_from_external | sec_latched_q[`BSCP_SB_CTR]; // R11 R12
  always @(posedge clk) begin
    if (rst) begin
      ctr_to_internal_q <= 1'b0;
      ctr_to_external_q <= 1'b0;
    end else begin
      ctr_to_internal_q <= code_table_read & ctr_addr_internal & ctr_int_ok; // R11 R12
      ctr_to_external_q <= code_table_read & ~(ctr_addr_internal & ctr_int_ok); // R11
    end
  end

  // **********************************
  // flash read lock
  // **********************************
  always @(posedge clk) begin
    if (rst) begin
      flash_rd_grant_q <= 1'b0;
    end else begin
      flash_rd_grant_q <= flash_rd_req & lock_n; // R10
    end
  end
endmodule // bscp_top

/* bscp_checker.sv */
// assertion checker for the boot source and code protection block
`timescale 1ns/10ps
module bscp_checker (
  input wire logic       clk, rst, boot_ctrl_wr, core_idle_enter, update_done,
  input wire logic       target_sel_wr, code_table_read, ctr_from_external, ctr_addr_internal,
  input wire logic       flash_rd_req, spec_rd, core_reset_q, boot_from_loader_q,
  input wire logic       update_busy_q, ctr_to_internal_q, flash_rd_grant_q, spec_refused_q,
  input wire logic       crystal_fast_q,
  input wire logic [7:0] boot_ctrl_wdata, flash_boot_control_q, sec_latched_q,
  input wire logic [1:0] target_sel_wdata, flash_target_q
);
  // ************************
  // properties
  // ************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire run = !core_reset_q && !update_busy_q && !boot_ctrl_wr;
  a_soft_reboot: assert property (boot_ctrl_wr && boot_ctrl_wdata == 8'h83 && !core_reset_q &&
    !update_busy_q |=> (core_reset_q && !boot_from_loader_q)[*8]) else $error("reboot wrong");
  a_idle_loader: assert property (core_idle_enter && flash_boot_control_q == 8'h03 && run
    |=> core_reset_q && boot_from_loader_q) else $error("idle loader switch wrong");
  a_idle_update: assert property (core_idle_enter && flash_boot_control_q == 8'h01 && run
    |=> update_busy_q && !core_reset_q) else $error("idle update wrong");
  a_update_hold: assert property (update_busy_q |=> update_busy_q == !$past(update_done))
    else $error("update busy wrong");
  a_target_sel: assert property (target_sel_wr && target_sel_wdata != 2'h3 && !core_reset_q
    |=> flash_target_q == $past(target_sel_wdata)) else $error("target select wrong");
  a_flash_lock: assert property (flash_rd_req |=> flash_rd_grant_q == $past(sec_latched_q[0]))
    else $error("flash read grant wrong");
  a_spec_hidden: assert property (spec_rd && (update_busy_q || boot_from_loader_q ||
    !sec_latched_q[0]) |=> spec_refused_q) else $error("special read not refused");
  a_ctr_ext: assert property (code_table_read && ctr_from_external && !sec_latched_q[1]
    |=> !ctr_to_internal_q) else $error("external table read reached internal");
  a_ctr_int: assert property (code_table_read && !ctr_from_external && ctr_addr_internal
    |=> ctr_to_internal_q) else $error("internal table read refused");
  a_xtal_flag: assert property (crystal_fast_q == sec_latched_q[7])
    else $error("crystal flag wrong");
  c_loader: cover property ($fell(core_reset_q) && boot_from_loader_q);
  c_update: cover property ($rose(update_busy_q));
  c_refuse: cover property (spec_refused_q);
endmodule // bscp_checker
bind bscp_top bscp_checker u_chk (.*);

/* bscp_board.sv */
// board model: reset pin pulse and strap levels with pull-ups
`timescale 1ns/10ps
module bscp_board (
  input  wire logic       clk, rst_req,
  input  wire logic [2:0] strap_low,
  output wire logic       ext_reset_pin, port2_bit6_strap, port2_bit7_strap, port4_bit3_strap
);
  logic [3:0] cnt_q = 4'h0;
  logic [2:0] low_q = 3'h0;
  always @(posedge clk) begin
    if (rst_req) begin
      cnt_q <= 4'h8;
      low_q <= strap_low;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign ext_reset_pin = cnt_q > 4'h4;
  // straps held from pin assert to four cycles after release, then pulled high
  assign {port4_bit3_strap, port2_bit7_strap, port2_bit6_strap} =
    (cnt_q != 4'h0) ? ~low_q : 3'h7;
endmodule // bscp_board

/* boot_source_and_code_protection_bench.sv */
// self-checking bench for the boot source and code protection block
`timescale 1ns/10ps
module boot_source_and_code_protection_bench;
  logic       clk = 0, rst = 1, rst_req = 0, ext_reset_pin, port2_bit6_strap, port2_bit7_strap;
  logic       port4_bit3_strap, core_idle_enter = 0, boot_ctrl_wr = 0, target_sel_wr = 0;
  logic       update_done = 0, code_table_read = 0, ctr_from_external = 0;
  logic       ctr_addr_internal = 1, flash_rd_req = 0, spec_wr = 0, spec_erase_all = 0;
  logic       spec_rd = 0, core_reset_q, boot_from_loader_q, update_busy_q, ctr_to_internal_q;
  logic       ctr_to_external_q, flash_rd_grant_q, spec_refused_q, spec_rvalid_q, crystal_fast_q;
  logic [2:0] strap_low = 0;
  logic [1:0] target_sel_wdata = 0, spec_addr = 0, flash_target_q;
  logic [7:0] boot_ctrl_wdata = 0, spec_wdata = 0, flash_boot_control_q, spec_rdata_q;
  logic [7:0] sec_latched_q;
  logic       refused_seen;
  integer     error_cnt = 0, num_checks = 0, i;
  bscp_board u_board (
    .clk (clk), .rst_req (rst_req), .strap_low (strap_low), .ext_reset_pin (ext_reset_pin),
    .port2_bit6_strap (port2_bit6_strap), .port2_bit7_strap (port2_bit7_strap),
    .port4_bit3_strap (port4_bit3_strap)
  );
  bscp_top dut (
    .clk (clk), .rst (rst), .ext_reset_pin (ext_reset_pin),
    .port2_bit6_strap (port2_bit6_strap), .port2_bit7_strap (port2_bit7_strap),
    .port4_bit3_strap (port4_bit3_strap), .core_idle_enter (core_idle_enter),
    .boot_ctrl_wr (boot_ctrl_wr), .boot_ctrl_wdata (boot_ctrl_wdata),
    .target_sel_wr (target_sel_wr), .target_sel_wdata (target_sel_wdata),
    .update_done (update_done), .code_table_read (code_table_read),
    .ctr_from_external (ctr_from_external), .ctr_addr_internal (ctr_addr_internal),
    .flash_rd_req (flash_rd_req), .spec_wr (spec_wr), .spec_erase_all (spec_erase_all),
    .spec_wdata (spec_wdata), .spec_rd (spec_rd), .spec_addr (spec_addr),
    .core_reset_q (core_reset_q), .boot_from_loader_q (boot_from_loader_q),
    .update_busy_q (update_busy_q), .flash_target_q (flash_target_q),
    .flash_boot_control_q (flash_boot_control_q), .ctr_to_internal_q (ctr_to_internal_q),
    .ctr_to_external_q (ctr_to_external_q), .flash_rd_grant_q (flash_rd_grant_q),
    .spec_refused_q (spec_refused_q), .spec_rdata_q (spec_rdata_q),
    .spec_rvalid_q (spec_rvalid_q), .crystal_fast_q (crystal_fast_q),
    .sec_latched_q (sec_latched_q)
  );
  initial forever #25 clk = ~clk;
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc;
    @(posedge clk);
  endtask
  task look;
    @(posedge clk);
    #1;
  endtask
  task wait_run;
    for (i = 0; i < 40 && core_reset_q !== 1'b0; i = i + 1) look;
    if (core_reset_q !== 1'b0) begin
      error_cnt = error_cnt + 1;
      end_of_test;
    end
  endtask
  task ext_boot(input logic [2:0] s, input logic e);
    cyc; rst_req <= 1; strap_low <= s;
    cyc; rst_req <= 0;
    repeat (6) cyc;
    wait_run;
    chk("loader", e, boot_from_loader_q);
  endtask
  task spec(input logic w, x, r, input logic [1:0] a, input logic [7:0] d);
    cyc; spec_wr <= w; spec_erase_all <= x; spec_rd <= r; spec_addr <= a; spec_wdata <= d;
    cyc; spec_wr <= 0; spec_erase_all <= 0; spec_rd <= 0;
    #1;
    refused_seen = spec_refused_q;
    look;
  endtask
  task sread(input logic [1:0] a, input logic [7:0] e);
    spec(0, 0, 1, a, 8'h00);
    chk("refused", 0, refused_seen);
    chk("spec_rvalid", 1, spec_rvalid_q);
    chk("spec_rdata", e, spec_rdata_q);
  endtask
  task bctl(input logic [7:0] d);
    cyc; boot_ctrl_wr <= 1; boot_ctrl_wdata <= d;
    cyc; boot_ctrl_wr <= 0;
    look;
  endtask
  task go_idle;
    cyc; core_idle_enter <= 1;
    cyc; core_idle_enter <= 0;
    look;
  endtask
  task ctab(input logic x, input logic e);
    cyc; code_table_read <= 1; ctr_from_external <= x;
    cyc; code_table_read <= 0;
    #1;
    chk("ctr_int", e, ctr_to_internal_q);
    chk("ctr_ext", !e, ctr_to_external_q);
  endtask
  task fread(input logic e);
    cyc; flash_rd_req <= 1;
    cyc; flash_rd_req <= 0;
    #1;
    chk("grant", e, flash_rd_grant_q);
  endtask
  task t_power_up;
    look;
    chk("loader", 0, boot_from_loader_q);
    chk("sec", 8'hff, sec_latched_q);
    chk("xtal", 1, crystal_fast_q);
    ext_boot(3'b111, 0);
  endtask
  task t_secbyte;
    spec(1, 0, 0, 2'h0, 8'h7e);
    spec(1, 0, 0, 2'h0, 8'hff);
    sread(2'h0, 8'h7e);
    sread(2'h1, 8'h5a);
    spec(1, 0, 0, 2'h2, 8'h00);
    sread(2'h2, 8'h3c);
    spec(0, 1, 0, 2'h0, 8'h00);
    sread(2'h0, 8'hff);
  endtask
  task t_straps;
    spec(1, 0, 0, 2'h0, 8'h4f);
    ext_boot(3'b011, 1);
    ext_boot(3'b001, 0);
    ext_boot(3'b100, 1);
    ext_boot(3'b000, 0);
    chk("sec", 8'h4f, sec_latched_q);
    chk("xtal", 0, crystal_fast_q);
  endtask
  task t_loader_flow;
    bctl(8'h03);
    go_idle;
    chk("reset", 1, core_reset_q);
    chk("loader", 1, boot_from_loader_q);
    chk("bctl", 8'h00, flash_boot_control_q);
    wait_run;
    spec(0, 0, 1, 2'h0, 8'h00);
    chk("refused", 1, refused_seen);
    for (int k = 0; k < 4; k++) begin
      cyc; target_sel_wr <= 1; target_sel_wdata <= k[1:0];
      cyc; target_sel_wr <= 0;
      look;
      chk("target", (k == 3) ? 8'h2 : k[7:0], {6'h0, flash_target_q});
    end
    bctl(8'h83);
    chk("reset", 1, core_reset_q);
    chk("loader", 0, boot_from_loader_q);
    wait_run;
  endtask
  task t_update;
    bctl(8'h01);
    chk("bctl", 8'h01, flash_boot_control_q);
    go_idle;
    chk("busy", 1, update_busy_q);
    chk("reset", 0, core_reset_q);
    cyc; update_done <= 1;
    cyc; update_done <= 0;
    look;
    chk("busy", 0, update_busy_q);
  endtask
  task t_lock;
    fread(1);
    spec(1, 0, 0, 2'h0, 8'hfc);
    ext_boot(3'b000, 0);
    fread(0);
    spec(0, 0, 1, 2'h1, 8'h00);
    chk("refused", 1, refused_seen);
    ctab(1, 0);
    ctab(0, 1);
  endtask
  initial begin
    repeat (5) cyc;
    rst <= 0;
    t_power_up;
    t_secbyte;
    t_straps;
    t_loader_flow;
    t_update;
    t_lock;
    end_of_test;
  end
endmodule // boot_source_and_code_protection_bench
